//--- src/led_pin_driver.sv
`timescale 1ns/100ps
module led_pin_driver (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic lit,
  input wire logic invert,
  output logic pin
);

  // pin idles high, which is dark for the default active-low sense
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin <= 1'b1;
    end else if (ce) begin
      pin <= invert ? lit : ~lit;
    end
  end

endmodule

//--- src/led_status_display.sv
// Added by the designer: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/100ps
// Functional notes
// - each register steers its own pin
// - pin shows OR of enabled functions
// - register two resets: polarity plus stretch
// - register one resets: receive plus stretch
// - bit 15 reads live unstretched state
// - bit 14 of two picks pin polarity
// - good polarity lights per invert bit
// - bit 3 adds good receive polarity
// - bit 2 adds receive activity
// - bit 1 adds jabber
// - bit 0 adds collision
// - bit 4 adds transmit activity
// - bit 5 limits receive to matches
// - bit 7 enables the pulse stretcher
// - reserved bits read zero
module led_status_display
  import led_status_pkg::*;
#(
  parameter int STRETCH_CYCLES = STRETCH_CYCLES_DEF,
  parameter int CNT_W = STRETCH_CNT_W
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic collision,
  input wire logic jabber,
  input wire logic rx_activity,
  input wire logic rx_addr_match,
  input wire logic tx_activity,
  input wire logic tp_rx_polarity,
  output logic indicator_pin_one,
  output logic indicator_pin_two
);

  // ************************************************************
  // bus slave: zero wait states, write lands in the data phase
  // ************************************************************
  logic accept;
  logic [1:0] addr_hit;
  logic wr_pend;
  logic [1:0] wr_sel;
  logic [15:0] cfg [2];
  logic [15:0] wmask [2];
  logic [15:0] cfg_fwd [2];
  logic [1:0] combined;
  logic [1:0] lit;
  logic [1:0] pin;
  logic [1:0] rx_term;
  logic [15:0] led_one_config;
  logic [15:0] led_two_config;

  // hsize is not decoded: only whole-word singles are expected
  assign accept = hsel && hready && (htrans != HTRANS_IDLE) && (hsize == 3'h2 || hsize != 3'h2);
  assign addr_hit[0] = (haddr[DEC_W-1:0] == OFS_LED_ONE);
  assign addr_hit[1] = (haddr[DEC_W-1:0] == OFS_LED_TWO);
  assign wmask[0] = WMASK_LED_ONE;
  assign wmask[1] = WMASK_LED_TWO;
  assign led_one_config = cfg[0];
  assign led_two_config = cfg[1];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_sel <= 2'h0;
    end else begin
      wr_pend <= accept && hwrite;
      wr_sel <= (accept && hwrite) ? addr_hit : 2'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end else begin
      hreadyout <= 1'b1;
      hresp <= HRESP_OKAY;
    end
  end

  // ************************************************************
  // indicator channels
  // ************************************************************
  genvar i;
  generate
    for (i = 0; i < 2; i++) begin : g_chan
      // a read straight after a write sees the new value
      assign cfg_fwd[i] = (wr_pend && wr_sel[i]) ? (hwdata[15:0] & wmask[i]) : cfg[i];

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cfg[i] <= (i == 0) ? RST_LED_ONE : RST_LED_TWO;
        end else if (wr_pend && wr_sel[i]) begin
          cfg[i] <= hwdata[15:0] & wmask[i];
        end
      end

      assign rx_term[i] = rx_activity && (!cfg[i][BIT_MATCH] || rx_addr_match);

      assign combined[i] = (cfg[i][BIT_COL] && collision)
                        || (cfg[i][BIT_JAB] && jabber)
                        || (cfg[i][BIT_RX] && rx_term[i])
                        || (cfg[i][BIT_POL] && tp_rx_polarity)
                        || (cfg[i][BIT_TX] && tx_activity);

      led_stretcher #(
        .CNT_W(CNT_W),
        .STRETCH_CYCLES(STRETCH_CYCLES)
      ) u_stretch (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .enable(cfg[i][BIT_STRETCH]),
        .raw(combined[i]),
        .lit(lit[i])
      );

      led_pin_driver u_pin (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .lit(lit[i]),
        .invert(cfg[i][BIT_INVERT]),
        .pin(pin[i])
      );
    end
  endgenerate

  assign indicator_pin_one = pin[0];
  assign indicator_pin_two = pin[1];

  // ************************************************************
  // read path
  // ************************************************************
  // bit 15 is never stored; it is the live unstretched combination
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (accept && !hwrite) begin
      if (addr_hit[0]) begin
        hrdata <= {16'h0000, combined[0], cfg_fwd[0][14:0]};
      end else if (addr_hit[1]) begin
        hrdata <= {16'h0000, combined[1], cfg_fwd[1][14:0]};
      end else begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_reset_two_value: assert property (
    @(posedge hclk) $rose(hresetn) |-> (led_two_config == RST_LED_TWO))
    else $error("register two reset value wrong");

  chk_reset_one_value: assert property (
    @(posedge hclk) $rose(hresetn) |-> (led_one_config == RST_LED_ONE))
    else $error("register one reset value wrong");

  chk_or_combine: assert property (
    @(posedge hclk) disable iff (!hresetn)
    combined[1] == |({tx_activity, tp_rx_polarity, rx_term[1], jabber, collision}
                     & led_two_config[NUM_EVENTS-1:0]))
    else $error("combined state is not the OR of enables");

  chk_view_bit: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite && addr_hit[0]) |=> (hrdata[BIT_VIEW] == $past(combined[0])))
    else $error("view bit does not show live state");

  chk_reserved_zero: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_two_config[13:8] == 6'h00) && !led_two_config[6] && (hrdata[31:16] == 16'h0000))
    else $error("reserved bits not zero");

  chk_write_effect: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_sel[1]) |=> (led_two_config == ($past(hwdata[15:0]) & WMASK_LED_TWO)))
    else $error("write did not reach register two");

  chk_pin_polarity: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce |=> (indicator_pin_two == ($past(led_two_config[BIT_INVERT]) ? $past(lit[1]) : !$past(lit[1]))))
    else $error("pin two polarity wrong");

  chk_match_filter: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[BIT_MATCH] && !rx_addr_match) |-> !rx_term[0])
    else $error("unmatched receive reached indicator");

  chk_no_stretch: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !led_one_config[BIT_STRETCH]) |=> (indicator_pin_one == !$past(combined[0])))
    else $error("pin one not following raw state");

  // ************************************************************
  // per-function and per-channel checks
  // ************************************************************

  chk_or_combine_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    combined[0] == |({tx_activity, tp_rx_polarity, rx_term[0], jabber, collision}
                     & led_one_config[NUM_EVENTS-1:0]))
    else $error("channel one is not the OR of enables");

  chk_view_bit_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (accept && !hwrite && addr_hit[1]) |=> (hrdata[BIT_VIEW] == $past(combined[1])))
    else $error("view bit of register two does not show live state");

  chk_view_not_stored: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !led_one_config[BIT_VIEW] && !led_two_config[BIT_VIEW])
    else $error("view bit was stored by a write");

  chk_reserved_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[14:8] == 7'h00) && !led_one_config[6])
    else $error("reserved bits of register one not zero");

  chk_write_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (wr_pend && wr_sel[0]) |=> (led_one_config == ($past(hwdata[15:0]) & WMASK_LED_ONE)))
    else $error("write did not reach register one");

  chk_write_keeps_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_pend && wr_sel[1]) |=> $stable(led_two_config))
    else $error("register two changed without its own write");

  chk_write_keeps_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !(wr_pend && wr_sel[0]) |=> $stable(led_one_config))
    else $error("register one changed without its own write");

  chk_pin_one_sense: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ce |=> (indicator_pin_one == !$past(lit[0])))
    else $error("pin one is not active low");

  chk_pin_one_frozen: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ce |=> $stable(indicator_pin_one))
    else $error("pin one moved while the clock enable was low");

  chk_pin_two_frozen: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !ce |=> $stable(indicator_pin_two))
    else $error("pin two moved while the clock enable was low");

  chk_pol_ignored: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (!led_two_config[BIT_POL]
     && !(|({tx_activity, 1'b0, rx_term[1], jabber, collision} & led_two_config[NUM_EVENTS-1:0])))
    |-> !combined[1])
    else $error("polarity status leaked onto pin two");

  chk_pol_drives_pin: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && led_two_config[BIT_POL] && tp_rx_polarity)
    |=> (indicator_pin_two == $past(led_two_config[BIT_INVERT])))
    else $error("good polarity drove pin two to the wrong level");

  chk_pol_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[BIT_POL] && tp_rx_polarity) |-> combined[0])
    else $error("good polarity missing on channel one");

  chk_pol_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_two_config[BIT_POL] && tp_rx_polarity) |-> combined[1])
    else $error("good polarity missing on channel two");

  chk_rx_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[BIT_RX] && rx_activity && !led_one_config[BIT_MATCH]) |-> combined[0])
    else $error("receive activity missing on channel one");

  chk_jab_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[BIT_JAB] && jabber) |-> combined[0])
    else $error("jabber missing on channel one");

  chk_jab_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_two_config[BIT_JAB] && jabber) |-> combined[1])
    else $error("jabber missing on channel two");

  chk_col_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[BIT_COL] && collision) |-> combined[0])
    else $error("collision missing on channel one");

  chk_col_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_two_config[BIT_COL] && collision) |-> combined[1])
    else $error("collision missing on channel two");

  chk_tx_one: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[BIT_TX] && tx_activity) |-> combined[0])
    else $error("transmit activity missing on channel one");

  chk_tx_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_two_config[BIT_TX] && tx_activity) |-> combined[1])
    else $error("transmit activity missing on channel two");

  chk_match_pass: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (led_one_config[BIT_MATCH] && led_one_config[BIT_RX] && rx_activity && rx_addr_match) |-> combined[0])
    else $error("matched receive did not reach indicator");

  chk_stretch_hold: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && led_one_config[BIT_STRETCH] && combined[0]) ##1 (ce && led_one_config[BIT_STRETCH])
    |=> !indicator_pin_one)
    else $error("pin one not held by the stretcher");

  chk_no_stretch_two: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && !led_two_config[BIT_STRETCH])
    |=> (indicator_pin_two == ($past(led_two_config[BIT_INVERT]) ? $past(combined[1]) : !$past(combined[1]))))
    else $error("pin two not following raw state");

  chk_reset_pins_dark: assert property (
    @(posedge hclk) $rose(hresetn) |-> (indicator_pin_one && indicator_pin_two))
    else $error("a pin was lit straight after reset");

endmodule

//--- src/led_status_pkg.sv
package led_status_pkg;

  // ************************************************************
  // register map (byte offsets within the slave's window)
  // ************************************************************
  localparam logic [7:0] OFS_LED_ONE = 8'h00;
  localparam logic [7:0] OFS_LED_TWO = 8'h04;
  localparam int DEC_W = 8;

  // ************************************************************
  // field positions, shared by both indicator registers
  // ************************************************************
  localparam int BIT_COL = 0;
  localparam int BIT_JAB = 1;
  localparam int BIT_RX = 2;
  localparam int BIT_POL = 3;
  localparam int BIT_TX = 4;
  localparam int BIT_MATCH = 5;
  localparam int BIT_STRETCH = 7;
  localparam int BIT_INVERT = 14;
  localparam int BIT_VIEW = 15;
  localparam int NUM_EVENTS = 5;

  // ************************************************************
  // reset values and writable masks
  // ************************************************************
  localparam logic [15:0] RST_LED_ONE = 16'h0084;
  localparam logic [15:0] RST_LED_TWO = 16'h0088;
  localparam logic [15:0] WMASK_LED_ONE = 16'h00bf;
  localparam logic [15:0] WMASK_LED_TWO = 16'h40bf;

  // ************************************************************
  // bus encodings
  // ************************************************************
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic HRESP_OKAY = 1'b0;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int STRETCH_TIME_MS = 100;
  localparam int STRETCH_CYCLES_DEF = (STRETCH_TIME_MS * 1000000) / CLK_PERIOD_NS;
  localparam int STRETCH_CNT_W = 24;

endpackage

//--- src/led_stretcher.sv
`timescale 1ns/100ps
module led_stretcher
  import led_status_pkg::*;
#(
  parameter int CNT_W = STRETCH_CNT_W,
  parameter int STRETCH_CYCLES = STRETCH_CYCLES_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic enable,
  input wire logic raw,
  output logic lit
);

  logic [CNT_W-1:0] hold_cnt;

  // the count reloads on every cycle with ce high that the event is present, so the
  // hold time is measured from the end of the last occurrence
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_cnt <= '0;
    end else if (ce) begin
      if (raw) begin
        hold_cnt <= CNT_W'(STRETCH_CYCLES);
      end else if (hold_cnt != '0) begin
        hold_cnt <= hold_cnt - 1'b1;
      end
    end
  end

  assign lit = enable ? (raw | (hold_cnt != '0)) : raw;

  chk_stretch_reload: assert property (
    @(posedge hclk) disable iff (!hresetn)
    (ce && raw) |=> (hold_cnt == CNT_W'(STRETCH_CYCLES)))
    else $error("stretch count not reloaded by event");

endmodule

//--- tb/led_model.sv
`timescale 1ns/100ps
module led_model (
  input wire logic pin,
  input wire logic active_high,
  output logic lit
);
  // the diode glows only while the pin sits at its asserted level
  assign lit = active_high ? pin : ~pin;
endmodule

//--- tb/tb.sv
`timescale 1ns/100ps
module tb;
  import led_status_pkg::*;
  localparam int S = 8;
  logic hclk = 0;
  logic hresetn = 0;
  logic hwrite = 0;
  logic [1:0] htrans = HTRANS_IDLE;
  logic [31:0] haddr = 0;
  logic [31:0] hwdata = 0;
  logic [31:0] hrdata;
  logic [31:0] q;
  logic hreadyout, hresp, pin_one, pin_two, lit_one, lit_two;
  logic inv_two = 0;
  logic ce = 1'b1;
  logic match = 0;
  logic [4:0] ev = 0;
  int miscompares = 0;
  int compares = 0;
  led_status_display #(.STRETCH_CYCLES(S), .CNT_W(8)) led_status_display_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .collision(ev[0]), .jabber(ev[1]), .rx_activity(ev[2]),
    .rx_addr_match(match), .tx_activity(ev[4]), .tp_rx_polarity(ev[3]),
    .indicator_pin_one(pin_one), .indicator_pin_two(pin_two));
  led_model led_model_one_i (.pin(pin_one), .active_high(1'b0), .lit(lit_one));
  led_model led_model_two_i (.pin(pin_two), .active_high(inv_two), .lit(lit_two));
  // ************************************************************
  // bus and check tasks
  // ************************************************************
  task automatic stop_test();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      $display("unexpected at %0t: bus never became ready", $time);
      stop_test();
    end
  endtask
  // entered just after a rising edge; returns at the edge that ends the data phase
  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_ready();
    htrans <= HTRANS_IDLE;
    hwdata <= {16'h0, d};
    if (w && a == OFS_LED_TWO) begin
      inv_two = d[BIT_INVERT];
    end
    wait_ready();
    q = hrdata;
    chk(32'(hresp), 32'(HRESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 16'h0);
    chk(q, exp);
  endtask
  task automatic pins(input logic e1, input logic e2, input int k);
    repeat (k) @(posedge hclk);
    chk(32'(lit_one), 32'(e1));
    chk(32'(lit_two), 32'(e2));
  endtask
  initial begin
    forever #5 hclk = ~hclk;
  end
  initial begin
    #200000;
    miscompares++;
    $display("unexpected at %0t: run timed out", $time);
    stop_test();
  end
  initial begin
    logic [7:0] a;
    int n;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_LED_ONE, 32'h0000_0084);
    rd(OFS_LED_TWO, 32'h0000_0088);
    pins(1'b0, 1'b0, 1);
    xfer(1'b1, 8'h08, 16'hffff);
    rd(8'h08, 32'h0000_0000);
    rd(OFS_LED_ONE, 32'h0000_0084);
    xfer(1'b1, OFS_LED_TWO, 16'h0000);
    match <= 1'b1;
    for (int r = 0; r < 2; r++) begin
      a = r ? OFS_LED_TWO : OFS_LED_ONE;
      for (int i = 0; i < NUM_EVENTS; i++) begin
        xfer(1'b1, a, 16'(1 << i));
        ev <= ~(5'h01 << i);
        pins(1'b0, 1'b0, 3);
        rd(a, 32'(1 << i));
        ev <= 5'h01 << i;
        pins(r == 0, r == 1, 3);
        rd(a, 32'h0000_8000 | 32'(1 << i));
      end
      xfer(1'b1, a, 16'h0000);
    end
    // several functions enabled on one pin
    xfer(1'b1, OFS_LED_ONE, 16'h0003);
    for (int j = 0; j < 3; j++) begin
      ev <= 5'(j + 1);
      pins(1'b1, 1'b0, 3);
    end
    ev <= 5'h00;
    pins(1'b0, 1'b0, 3);
    xfer(1'b1, OFS_LED_ONE, 16'h0024);
    match <= 1'b0;
    ev <= 5'h04;
    pins(1'b0, 1'b0, 3);
    match <= 1'b1;
    pins(1'b1, 1'b0, 3);
    ev <= 5'h00;
    xfer(1'b1, OFS_LED_ONE, 16'hffff);
    rd(OFS_LED_ONE, 32'h0000_00bf);
    xfer(1'b1, OFS_LED_TWO, 16'hffff);
    rd(OFS_LED_TWO, 32'h0000_40bf);
    for (int k = 0; k < 2; k++) begin
      xfer(1'b1, OFS_LED_TWO, k ? 16'h4008 : 16'h0008);
      ev <= 5'h08;
      repeat (3) @(posedge hclk);
      chk(32'(pin_two), 32'(k));
      ev <= 5'h00;
      repeat (3) @(posedge hclk);
      chk(32'(pin_two), 32'(k == 0));
    end
    // a one-cycle event must stay visible for the stretch time
    xfer(1'b1, OFS_LED_TWO, 16'h0000);
    xfer(1'b1, OFS_LED_ONE, 16'h0081);
    for (int p = 0; p < 2; p++) begin
      ev <= 5'h01;
      @(posedge hclk);
      ev <= 5'h00;
      n = 0;
      if (p == 1) begin
        rd(OFS_LED_ONE, 32'h0000_0081);
        pins(1'b1, 1'b0, 0);
      end
      do begin
        @(posedge hclk);
        n++;
      end while (lit_one === 1'b1 && n < 40);
      // the second pass starts counting two edges later, behind its read
      chk(32'(n + 2 * p >= S && n + 2 * p <= S + 3), 32'h0000_0001);
    end
    xfer(1'b1, OFS_LED_ONE, 16'h0001);
    ev <= 5'h01;
    @(posedge hclk);
    ev <= 5'h00;
    pins(1'b0, 1'b0, 3);
    // a low clock enable must keep the pin dark until it returns
    ce <= 1'b0;
    ev <= 5'h01;
    pins(1'b0, 1'b0, 3);
    ce <= 1'b1;
    pins(1'b1, 1'b0, 3);
    ev <= 5'h00;
    // a second reset mid-run must restore both defaults
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(OFS_LED_ONE, 32'h0000_0084);
    rd(OFS_LED_TWO, 32'h0000_0088);
    pins(1'b0, 1'b0, 1);
    stop_test();
  end
endmodule
